// ---- verilog/can_tx_pkg.sv ----
// constants, codes and carrier types for the transmit scheduler
package can_tx_pkg;

	// ----------------------------------------------------------------
	// buffer geometry
	// ----------------------------------------------------------------
	localparam int         NUM_BUF   = 15;
	localparam int         IDX_W     = 4;
	localparam int         ERR_W     = 5;
	localparam int         ERR_FLAG  = 15;
	localparam int         RANK_LSB  = 4;
	localparam int         BUSY_BIT  = 0;
	localparam int         TXCFG_BIT = 3;

	// ----------------------------------------------------------------
	// buffer condition codes, busy form adds bit 0
	// ----------------------------------------------------------------
	localparam logic [3:0] ST_RX_IDLE    = 4'h0;
	localparam logic [3:0] ST_RX_READY   = 4'h2;
	localparam logic [3:0] ST_TX_IDLE    = 4'h8;
	localparam logic [3:0] ST_TX_SINGLE  = 4'hc;
	localparam logic [3:0] ST_AWAIT_RMT  = 4'ha;
	localparam logic [3:0] ST_SEND_AWAIT = 4'he;
	localparam logic [3:0] ST_SEND_BUSY  = 4'hf;
	localparam logic [3:0] BUSY_CLR_MASK = 4'he;
	localparam logic [3:0] BUSY_SET_MASK = 4'h1;

	// ----------------------------------------------------------------
	// apb byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BUF_BASE = 8'h00;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h40;
	localparam logic [7:0] ADDR_IRQ_FLAG = 8'h44;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h48;
	localparam logic [7:0] ADDR_ERR_DIAG = 8'h4c;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] IRQ_EN_RST   = 16'h0000;
	localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

	// events from the can bit engine, one-cycle pulses
	typedef struct packed {
		logic crc_start;   // crc field of the running frame begins
		logic frame_start; // sof of the frame taken from tx_req
		logic tx_ok;       // running frame sent without error
		logic tx_remote;   // with tx_ok: the frame was a remote frame
		logic tx_fail;     // error or lost arbitration
		logic resume;      // foreign frame or error signalling over
	} link_evt_s;

endpackage : can_tx_pkg

// ---- verilog/can_tx_scheduler.sv ----
// transmit scheduler with buffer status words and apb register file
//
// Behaviour
// - single-request write starts transmit, sets busy
// - busy transmit buffer: only condition bits writable
// - from crc start pick best pending request
// - current and scheduled both busy until start
// - pre-empted buffer drops busy, back to its request code
// - after failure wait for resume, reselect
// - writes to busy bit always ignored
// - arbitrate again right after each message
// - rank is code high nibble, index low
// - equal rank: lower buffer number wins
// - single or send-await code raises request
// - await-remote buffer answers remote frame automatically
// - after send: idle if data, ready if remote
// - send-await shows 1111b, then await remote
// - 1010b waits for remote frame, sends nothing
// - one irq output, receive events to wakeup
// - irq on listed buffer condition transitions
// - protocol error sets flag and diagnosis bits
// - per-buffer enable, flags cleared by clear register
// - condition bit 3 means transmit buffer
// - condition bit 0 is busy
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps

module can_tx_scheduler (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// can bit engine
	input  can_tx_pkg::link_evt_s      lk,
	input  wire logic [14:0]           rmt_match,
	input  wire logic [14:0]           rx_evt,
	input  wire logic [4:0]            err_cause,
	output logic                       tx_req,
	output logic      [3:0]            tx_idx,
	// system
	output logic                       irq,
	output logic                       wakeup_evt
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PH_IDLE, PH_SEND, PH_HALT} phase_e;

	phase_e      phase_r;
	logic [3:0]  st_r    [can_tx_pkg::NUM_BUF];
	logic [3:0]  rank_r  [can_tx_pkg::NUM_BUF];
	logic [3:0]  cur_i_r;
	logic [3:0]  sch_i_r;
	logic        sch_v_r;
	logic        open_r;
	logic [15:0] en_r;
	logic [15:0] flags_r;
	logic [4:0]  diag_r;
	logic [31:0] prdata_r;
	logic        irq_r;
	logic        wake_r;

	logic        apb_wr;
	logic        apb_setup;
	logic        wr_buf;
	logic [3:0]  wr_idx;
	logic        cancel;
	logic        best_v;
	logic [3:0]  best_i;
	logic [7:0]  best_rk;
	logic [7:0]  sch_rk;
	logic        pick;
	logic        ok_now;
	logic [14:0] tx_evt;
	logic [14:0] rmt_evt;
	logic [15:0] clr_vec;
	logic [15:0] keep_flags;

	// rank of a buffer: software code above, buffer number below
	function automatic logic [7:0] comb_rank(input logic [3:0] code, input logic [3:0] idx);
		comb_rank = {code, idx};
	endfunction : comb_rank

	// a request waits when bits 3 and 2 are set and the buffer is not busy
	function automatic logic is_pending(input logic [3:0] st);
		is_pending = st[can_tx_pkg::TXCFG_BIT] && st[2] && !st[can_tx_pkg::BUSY_BIT];
	endfunction : is_pending

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero wait states; read data is captured in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign wr_idx    = paddr[5:2];
	assign wr_buf    = apb_wr && (paddr < can_tx_pkg::ADDR_IRQ_EN) && (paddr[1:0] == 2'b00)
	                   && (wr_idx != 4'hf);
	assign pready    = 1'b1;
	assign prdata    = prdata_r;
	assign clr_vec   = (apb_wr && paddr == can_tx_pkg::ADDR_IRQ_CLR) ? pwdata[15:0] : 16'h0000;
	// writing a non-request code to the scheduled buffer withdraws it
	assign cancel    = wr_buf && sch_v_r && (wr_idx == sch_i_r)
	                   && (pwdata[3:2] != 2'b11);

	// unmapped or misaligned addresses answer with an error
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			if (paddr[1:0] != 2'b00) begin
				pslverr = 1'b1;
			end else if (paddr > can_tx_pkg::ADDR_ERR_DIAG || paddr[7:2] == 6'h0f) begin
				pslverr = 1'b1;
			end
		end
	end

	// read mux into the data flop
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata_r <= can_tx_pkg::RDATA_ZERO;
		end else if (apb_setup) begin
			prdata_r <= can_tx_pkg::RDATA_ZERO;
			if (paddr < can_tx_pkg::ADDR_IRQ_EN && paddr[7:2] != 6'h0f) begin
				prdata_r[7:0] <= {rank_r[paddr[5:2]], st_r[paddr[5:2]]};
			end else begin
				case (paddr)
					can_tx_pkg::ADDR_IRQ_EN:   prdata_r[15:0] <= en_r;
					can_tx_pkg::ADDR_IRQ_FLAG: prdata_r[15:0] <= flags_r;
					can_tx_pkg::ADDR_ERR_DIAG: prdata_r[4:0]  <= diag_r;
					default:                   prdata_r       <= can_tx_pkg::RDATA_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	// ascending scan with strict compare keeps the lower number on a tie
	always_comb begin
		best_v  = 1'b0;
		best_i  = 4'h0;
		best_rk = 8'hff;
		for (int i = 0; i < can_tx_pkg::NUM_BUF; i++) begin
			if (is_pending(st_r[i]) && (!best_v || comb_rank(rank_r[i], 4'(i)) < best_rk)) begin
				best_v  = 1'b1;
				best_i  = 4'(i);
				best_rk = comb_rank(rank_r[i], 4'(i));
			end
		end
	end

	assign sch_rk = comb_rank(rank_r[sch_i_r], sch_i_r);
	// a cpu write to any buffer holds off the pick one cycle, so a cancel
	// and a pick of the same buffer never race
	assign pick   = (phase_r == PH_IDLE || (phase_r == PH_SEND && open_r))
	                && !lk.frame_start && best_v && !wr_buf
	                && (!sch_v_r || best_rk < sch_rk);
	assign ok_now = (phase_r == PH_SEND) && lk.tx_ok;

	// the engine may arbitrate as soon as a request is scheduled, so back
	// to back frames need no idle gap
	assign tx_req = sch_v_r && (phase_r != PH_HALT);
	assign tx_idx = sch_i_r;

	// ----------------------------------------------------------------
	// buffer conditions and scheduling
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < can_tx_pkg::NUM_BUF; i++) begin
				st_r[i]   <= can_tx_pkg::ST_RX_IDLE;
				rank_r[i] <= 4'h0;
			end
			phase_r <= PH_IDLE;
			cur_i_r <= 4'h0;
			sch_i_r <= 4'h0;
			sch_v_r <= 1'b0;
			open_r  <= 1'b0;
		end else begin
			for (int i = 0; i < can_tx_pkg::NUM_BUF; i++) begin
				if (wr_buf && wr_idx == 4'(i)) begin
					// the busy bit always keeps the hardware value
					if (st_r[i][can_tx_pkg::TXCFG_BIT] && st_r[i][can_tx_pkg::BUSY_BIT]) begin
						st_r[i] <= {pwdata[3:1], st_r[i][can_tx_pkg::BUSY_BIT]};
					end else begin
						rank_r[i] <= pwdata[7:4];
						st_r[i]   <= {pwdata[3:1], st_r[i][can_tx_pkg::BUSY_BIT]};
					end
				end
				if (rmt_match[i] && st_r[i] == can_tx_pkg::ST_AWAIT_RMT) begin
					st_r[i] <= can_tx_pkg::ST_SEND_AWAIT;
				end
			end
			if (cancel) begin
				st_r[sch_i_r] <= {pwdata[3:1], 1'b0};
				sch_v_r       <= 1'b0;
			end
			case (phase_r)
				PH_IDLE: begin
					if (lk.frame_start && sch_v_r && !cancel) begin
						cur_i_r <= sch_i_r;
						sch_v_r <= 1'b0;
						open_r  <= 1'b0;
						phase_r <= PH_SEND;
					end
				end
				PH_SEND: begin
					if (lk.crc_start) begin
						open_r <= 1'b1;
					end
					if (lk.tx_ok) begin
						if (st_r[cur_i_r] == can_tx_pkg::ST_SEND_BUSY) begin
							st_r[cur_i_r] <= can_tx_pkg::ST_AWAIT_RMT;
						end else if (lk.tx_remote) begin
							st_r[cur_i_r] <= can_tx_pkg::ST_RX_READY;
						end else begin
							st_r[cur_i_r] <= can_tx_pkg::ST_TX_IDLE;
						end
						phase_r <= PH_IDLE;
					end else if (lk.tx_fail) begin
						phase_r <= PH_HALT;
						open_r  <= 1'b0;
					end
					if (lk.frame_start && sch_v_r && !cancel) begin
						cur_i_r <= sch_i_r;
						sch_v_r <= 1'b0;
						open_r  <= 1'b0;
						phase_r <= PH_SEND;
					end
				end
				PH_HALT: begin
					// the failed buffer stays busy and re-enters selection
					if (lk.resume) begin
						// a cancel in this cycle has already stored the written code
						if (sch_v_r && !cancel) begin
							st_r[sch_i_r] <= st_r[sch_i_r] & can_tx_pkg::BUSY_CLR_MASK;
						end
						sch_i_r <= cur_i_r;
						sch_v_r <= 1'b1;
						phase_r <= PH_IDLE;
					end
				end
				default: begin
					phase_r <= PH_IDLE;
				end
			endcase
			if (pick) begin
				if (sch_v_r) begin
					st_r[sch_i_r] <= st_r[sch_i_r] & can_tx_pkg::BUSY_CLR_MASK;
				end
				st_r[best_i] <= st_r[best_i] | can_tx_pkg::BUSY_SET_MASK;
				sch_i_r      <= best_i;
				sch_v_r      <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags, enables and error diagnosis
	// ----------------------------------------------------------------
	always_comb begin
		tx_evt  = 15'h0000;
		rmt_evt = 15'h0000;
		for (int i = 0; i < can_tx_pkg::NUM_BUF; i++) begin
			tx_evt[i]  = ok_now && cur_i_r == 4'(i);
			rmt_evt[i] = rmt_match[i] && st_r[i] == can_tx_pkg::ST_AWAIT_RMT;
		end
	end

	assign keep_flags = flags_r & ~clr_vec;

	// set beats clear: an event in the clearing cycle survives
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flags_r <= 16'h0000;
			diag_r  <= 5'h00;
			en_r    <= can_tx_pkg::IRQ_EN_RST;
		end else begin
			flags_r[14:0] <= keep_flags[14:0] | tx_evt | rmt_evt | rx_evt;
			flags_r[can_tx_pkg::ERR_FLAG] <= keep_flags[can_tx_pkg::ERR_FLAG] | (|err_cause);
			if (apb_wr && paddr == can_tx_pkg::ADDR_ERR_DIAG) begin
				diag_r <= (diag_r & ~pwdata[4:0]) | err_cause;
			end else begin
				diag_r <= diag_r | err_cause;
			end
			if (apb_wr && paddr == can_tx_pkg::ADDR_IRQ_EN) begin
				en_r <= pwdata[15:0];
			end
		end
	end

	// one request line for all sources, receive events to wakeup
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_r  <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			irq_r  <= |(flags_r & en_r);
			wake_r <= |rx_evt;
		end
	end

	assign irq        = irq_r;
	assign wakeup_evt = wake_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fail;
		(phase_r == PH_SEND) && !lk.tx_ok && lk.tx_fail && !lk.frame_start;
	endsequence

	sequence s_halted;
		(phase_r == PH_HALT) && !pick;
	endsequence

	property p_sched_busy;
		sch_v_r |-> st_r[sch_i_r][can_tx_pkg::BUSY_BIT];
	endproperty
	a_sched_busy: assert property (p_sched_busy) else $error("scheduled buffer not busy");

	property p_cur_busy;
		(phase_r == PH_SEND) |-> st_r[cur_i_r][can_tx_pkg::BUSY_BIT];
	endproperty
	a_cur_busy: assert property (p_cur_busy) else $error("sending buffer not busy");

	property p_preempt;
		(pick && sch_v_r && !cancel && !(phase_r == PH_SEND && lk.tx_ok && cur_i_r == sch_i_r))
		|=> st_r[$past(sch_i_r)][3:0] == can_tx_pkg::ST_TX_SINGLE
		    || st_r[$past(sch_i_r)][3:0] == can_tx_pkg::ST_SEND_AWAIT;
	endproperty
	a_preempt: assert property (p_preempt) else $error("displaced buffer not pending");

	property p_halt;
		s_fail |=> s_halted ##1 (phase_r == PH_HALT || $past(lk.resume));
	endproperty
	a_halt: assert property (p_halt) else $error("selection ran during halt");

	property p_pick_best;
		pick |-> !sch_v_r || best_rk < sch_rk;
	endproperty
	a_pick_best: assert property (p_pick_best) else $error("pick did not improve rank");

	property p_ok_data;
		(ok_now && !lk.tx_remote && !pick
		 && st_r[cur_i_r] == (can_tx_pkg::ST_TX_SINGLE | can_tx_pkg::BUSY_SET_MASK))
		|=> st_r[$past(cur_i_r)] == can_tx_pkg::ST_TX_IDLE;
	endproperty
	a_ok_data: assert property (p_ok_data) else $error("sent buffer not idle");

	property p_ok_await;
		(ok_now && st_r[cur_i_r] == can_tx_pkg::ST_SEND_BUSY && !pick)
		|=> st_r[$past(cur_i_r)] == can_tx_pkg::ST_AWAIT_RMT && flags_r[$past(cur_i_r)];
	endproperty
	a_ok_await: assert property (p_ok_await) else $error("send-await did not return");

	property p_flags_hold;
		1'b1 |=> (flags_r & $past(keep_flags)) == $past(keep_flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag lost without clear");

	property p_irq_out;
		1'b1 |=> irq == $past(|(flags_r & en_r)) ##1 irq == $past(|(flags_r & en_r));
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq does not follow flags");

	property p_err_flag;
		(|err_cause) |=> flags_r[can_tx_pkg::ERR_FLAG] && ((diag_r & $past(err_cause)) != 5'h00);
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error not recorded");

endmodule : can_tx_scheduler

// ---- test/can_engine_model.sv ----
// behavioural can bit engine and bus peers facing the scheduler
`timescale 1ns/100ps

module can_engine_model (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// scheduler side
	input  wire logic             tx_req,
	output can_tx_pkg::link_evt_s lk,
	// bench controls
	input  wire logic             hold,
	input  wire logic             fail_now,
	input  wire logic             rmt_frm
);
	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	// long crc-to-end gap leaves the bench time to pre-empt on the wire
	initial begin
		lk = '0;
		forever begin
			@(posedge ref_clk);
			if (rst_n && tx_req && !hold) begin
				lk.frame_start <= 1'b1;
				@(posedge ref_clk);
				lk.frame_start <= 1'b0;
				repeat (8) @(posedge ref_clk);
				lk.crc_start <= 1'b1;
				@(posedge ref_clk);
				lk.crc_start <= 1'b0;
				repeat (30) @(posedge ref_clk);
				if (fail_now) begin
					lk.tx_fail <= 1'b1;
					@(posedge ref_clk);
					lk.tx_fail <= 1'b0;
					// error flag of another node occupies the bus first
					repeat (6) @(posedge ref_clk);
					lk.resume <= 1'b1;
					@(posedge ref_clk);
					lk.resume <= 1'b0;
				end else begin
					lk.tx_ok     <= 1'b1;
					lk.tx_remote <= rmt_frm;
					@(posedge ref_clk);
					lk.tx_ok     <= 1'b0;
					lk.tx_remote <= 1'b0;
				end
			end
		end
	end
endmodule : can_engine_model

// ---- test/testbench.sv ----
// self-checking bench for the transmit scheduler
`timescale 1ns/100ps

module testbench;
	typedef struct packed {
		logic        err;
		logic [31:0] dat;
	} rd_note_s;

	logic                  ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic                  tx_req, irq, wakeup_evt, hold, fail_now, rmt_frm;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata;
	logic [14:0]           rmt_match, rx_evt;
	logic [4:0]            err_cause, cause;
	logic [3:0]            tx_idx;
	can_tx_pkg::link_evt_s lk;
	rd_note_s              rd_q[$];
	rd_note_s              n;
	logic [3:0]            exp_tx[$];
	int                    err_total, samples_checked, seed;
	int                    cyc = 0;

	can_tx_scheduler dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lk(lk), .rmt_match(rmt_match), .rx_evt(rx_evt),
		.err_cause(err_cause), .tx_req(tx_req), .tx_idx(tx_idx), .irq(irq),
		.wakeup_evt(wakeup_evt));
	can_engine_model peer (.ref_clk(ref_clk), .rst_n(rst_n), .tx_req(tx_req), .lk(lk),
		.hold(hold), .fail_now(fail_now), .rmt_frm(rmt_frm));

	// ----------------------------------------------------------------
	// clock, tasks and watchers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic end_sim;
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic chk(input logic c, input string m);
		samples_checked++;
		if (c !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk

	// one transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		rd_q.push_back({er, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// waits for a fresh pulse on one event bit, bounded
	task automatic wt(input int b);
		logic [5:0] v;
		int         k;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			v = lk;
			k++;
		end while (!v[b] && k < 500);
		chk(v[b], "engine event missing");
	endtask : wt

	// read results and frame starts are matched against the oldest note
	always @(posedge ref_clk) begin
		cyc++;
		if (psel && penable && pready && !pwrite) begin
			n = rd_q.pop_front();
			samples_checked++;
			if (pslverr !== n.err || (!n.err && prdata !== n.dat)) begin
				err_total++;
				$display("unexpected at %0t: read %h gave %h err %b", $time, paddr, prdata, pslverr);
			end
		end
		if (lk.frame_start && tx_req) begin
			samples_checked++;
			if (exp_tx.size() == 0 || tx_idx !== exp_tx[0]) begin
				err_total++;
				$display("unexpected at %0t: frame from buffer %0d", $time, tx_idx);
			end
			if (exp_tx.size() != 0)
				void'(exp_tx.pop_front());
		end
		// hang guard, far above the roughly 600 cycles the run needs
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 47923;
		err_total = 0;
		samples_checked = 0;
		{psel, penable, pwrite, fail_now, rmt_frm} = '0;
		hold = 1'b1;
		paddr = '0;
		pwdata = '0;
		rmt_match = '0;
		rx_evt = '0;
		err_cause = '0;
		rst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h00, 32'h0000_0000, 1'b0);
		rd(8'h40, 32'h0000_0000, 1'b0);
		rd(8'h44, 32'h0000_0000, 1'b0);
		rd(8'h4c, 32'h0000_0000, 1'b0);
		rd(8'h3c, 32'h0000_0000, 1'b1);
		rd(8'h4d, 32'h0000_0000, 1'b1);
		$display("test reset done");
		apb(1'b1, 8'h28, 32'h0000_0009);
		rd(8'h28, 32'h0000_0008, 1'b0);
		apb(1'b1, 8'h08, 32'h0000_000c);
		repeat (4) @(posedge ref_clk);
		rd(8'h08, 32'h0000_000d, 1'b0);
		apb(1'b1, 8'h08, 32'h0000_00fd);
		rd(8'h08, 32'h0000_000d, 1'b0);
		$display("test busy done");
		apb(1'b1, 8'h14, 32'h0000_003c);
		apb(1'b1, 8'h04, 32'h0000_003c);
		apb(1'b1, 8'h24, 32'h0000_001c);
		apb(1'b1, 8'h1c, 32'h0000_000c);
		apb(1'b1, 8'h1c, 32'h0000_0008);
		exp_tx = '{4'd2, 4'd9, 4'd0, 4'd1, 4'd5};
		hold <= 1'b0;
		wt(5);
		wt(5);
		repeat (2) @(posedge ref_clk);
		rd(8'h24, 32'h0000_001d, 1'b0);
		rd(8'h04, 32'h0000_003d, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_000c);
		repeat (3) @(posedge ref_clk);
		rd(8'h04, 32'h0000_003c, 1'b0);
		rd(8'h00, 32'h0000_000d, 1'b0);
		repeat (4) wt(3);
		chk(exp_tx.size() == 0, "frames left over");
		rd(8'h08, 32'h0000_0008, 1'b0);
		rd(8'h1c, 32'h0000_0008, 1'b0);
		$display("test priority done");
		apb(1'b1, 8'h40, 32'h0000_0004);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(irq === 1'b1, "irq not raised");
		rd(8'h44, 32'h0000_0227, 1'b0);
		apb(1'b1, 8'h44, 32'h0000_0000);
		rd(8'h44, 32'h0000_0227, 1'b0);
		apb(1'b1, 8'h40, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(irq === 1'b0, "irq not masked");
		apb(1'b1, 8'h48, 32'h0000_0227);
		rd(8'h44, 32'h0000_0000, 1'b0);
		$display("test interrupt done");
		fail_now <= 1'b1;
		exp_tx = '{4'd3, 4'd3};
		apb(1'b1, 8'h0c, 32'h0000_000c);
		wt(1);
		@(posedge ref_clk);
		fail_now <= 1'b0;
		wt(3);
		rd(8'h0c, 32'h0000_0008, 1'b0);
		chk(exp_tx.size() == 0, "no retry frame");
		$display("test retry done");
		apb(1'b1, 8'h10, 32'h0000_000a);
		repeat (20) @(posedge ref_clk);
		rd(8'h10, 32'h0000_000a, 1'b0);
		exp_tx = '{4'd4};
		@(posedge ref_clk);
		rmt_match <= 15'h0010;
		@(posedge ref_clk);
		rmt_match <= '0;
		wt(4);
		rd(8'h10, 32'h0000_000f, 1'b0);
		wt(3);
		rd(8'h10, 32'h0000_000a, 1'b0);
		exp_tx = '{4'd6};
		apb(1'b1, 8'h18, 32'h0000_000e);
		wt(4);
		rd(8'h18, 32'h0000_000f, 1'b0);
		wt(3);
		rd(8'h18, 32'h0000_000a, 1'b0);
		rmt_frm <= 1'b1;
		exp_tx = '{4'd8};
		apb(1'b1, 8'h20, 32'h0000_000c);
		wt(3);
		@(posedge ref_clk);
		rmt_frm <= 1'b0;
		rd(8'h20, 32'h0000_0002, 1'b0);
		$display("test remote done");
		// engine held off so the scheduled request can be withdrawn
		hold <= 1'b1;
		apb(1'b1, 8'h2c, 32'h0000_000c);
		repeat (2) @(posedge ref_clk);
		rd(8'h2c, 32'h0000_000d, 1'b0);
		apb(1'b1, 8'h2c, 32'h0000_0008);
		rd(8'h2c, 32'h0000_0008, 1'b0);
		#1;
		chk(tx_req === 1'b0, "cancel left request");
		$display("test cancel done");
		// a random non-empty set of causes
		cause = 5'($random(seed)) | 5'h01;
		@(posedge ref_clk);
		err_cause <= cause;
		@(posedge ref_clk);
		err_cause <= '0;
		rd(8'h4c, 32'(cause), 1'b0);
		rd(8'h44, 32'h0000_8158, 1'b0);
		apb(1'b1, 8'h4c, 32'(cause));
		rd(8'h4c, 32'h0000_0000, 1'b0);
		@(posedge ref_clk);
		rx_evt <= 15'h0008;
		@(posedge ref_clk);
		rx_evt <= '0;
		#1;
		chk(wakeup_evt === 1'b1, "no wakeup pulse");
		$display("test error done");
		end_sim();
	end
endmodule : testbench
